/* File: logic/vme_host_port.sv */
// host port logic of the network controller board: reset port, status/command port, bring-up
`include "vme_port_defs.svh"

module vme_host_port
#(
	parameter int unsigned BLINK_CYCLES = `LED_BLINK_CYC // indicator phase length
)
(
	input  wire logic                     i_clock,           // 40 MHz clock
	input  wire logic                     i_resetn,          // async reset, active low
	input  wire logic                     i_ce,              // clock enable
	input  wire logic                     i_sysreset,        // bus system reset pin
	input  wire vme_port_pkg::host_pins_t i_host,            // host port strobes and data
	input  wire logic                     i_netboot_strap,   // strap: net download
	input  wire logic                     i_selftest_pass,   // self-test passed, pulse
	input  wire logic                     i_selftest_fail,   // self-test failed, pulse
	input  wire logic [7:0]               i_fail_code,       // code for a failed self-test
	input  wire logic                     i_cpu_take,        // CPU read the command byte
	input  wire logic                     i_conv_enable,     // data order conversion on
	input  wire logic                     i_pat_valid,       // pattern words fetched
	input  wire logic [31:0]              i_pat_bytes,       // pattern offsets 0..3
	input  wire logic [31:0]              i_pat_words,       // pattern offsets 4..7
	input  wire logic [31:0]              i_pat_long,        // pattern offsets 8..11
	input  wire logic [31:0]              i_data,            // raw host memory data
	input  wire vme_port_pkg::dtype_t     i_dtype,           // type of i_data
	input  wire logic                     i_cfg_result_valid,// firmware finished the message
	input  wire logic [7:0]               i_cfg_result_code, // firmware result code
	input  wire logic                     i_host_irq_req,    // request to interrupt host
	input  wire logic                     i_irq_by_mem,      // method: memory write
	output logic [7:0]                    o_rdata,           // status byte
	output logic                          o_board_reset,     // board reset, pulse on reset port write, held while system reset is in
	output logic                          o_cpu_irq,         // command byte interrupt
	output logic [7:0]                    o_cmd_byte,        // latched command byte
	output logic                          o_netboot_req,     // start net download
	output logic                          o_fetch_req,       // fetch message, pulse
	output vme_port_pkg::cfg_req_t        o_cfg,             // message address
	output logic [31:0]                   o_data,            // converted data
	output vme_port_pkg::conv_t           o_conv,            // active conversions
	output logic                          o_complete_valid,  // completion code, pulse
	output logic [7:0]                    o_complete_code,   // completion code
	output logic                          o_vme_irq,         // bus interrupt line
	output logic                          o_mem_irq_req,     // memory interrupt write
	output logic                          o_led              // status indicator
);

	if (BLINK_CYCLES < 2)
		$error("BLINK_CYCLES must be at least 2");

	vme_port_pkg::host_pins_t host_s1_r;
	vme_port_pkg::host_pins_t host_s2_r;
	vme_port_pkg::host_pins_t host_p_r;
	logic [1:0]               sysr_r;
	logic [1:0]               strap_r;
	logic                     wr_evt;
	logic                     wr_a;
	logic                     wr_b;
	logic                     clear;
	logic [63:0]              seq_full;

	// two flops on every pin, then a copy of the host pins for edge detection
	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			host_s1_r <= '0;
			host_s2_r <= '0;
			host_p_r <= '0;
			sysr_r <= '0;
			strap_r <= '0;
		end
		else if (i_ce)
		begin
			host_s1_r <= i_host;
			host_s2_r <= host_s1_r;
			host_p_r <= host_s2_r;
			sysr_r <= {sysr_r[0], i_sysreset};
			strap_r <= {strap_r[0], i_netboot_strap};
		end
	end

	assign wr_evt = host_s2_r.wr && !host_p_r.wr;
	assign wr_a = wr_evt && !host_s2_r.sel_b;
	assign wr_b = wr_evt && host_s2_r.sel_b;
	assign clear = wr_a || sysr_r[1];

	vme_port_pkg::state_t   state_r;
	vme_port_pkg::state_t   state_nxt;
	vme_port_pkg::cfg_req_t cfg_r;
	vme_port_pkg::cfg_req_t cfg_nxt;
	logic [63:0]            seq_r;
	logic [63:0]            seq_nxt;
	logic [2:0]             cnt_r;
	logic [2:0]             cnt_nxt;
	logic [7:0]             err_r;
	logic [7:0]             err_nxt;
	logic [7:0]             cmd_r;
	logic [7:0]             cmd_nxt;
	logic [7:0]             rdata_r;
	logic [7:0]             rdata_nxt;
	logic [7:0]             code_r;
	logic [7:0]             code_nxt;
	logic                   ok_r;
	logic                   ok_nxt;
	logic                   pend_r;
	logic                   pend_nxt;
	logic                   irq_r;
	logic                   irq_nxt;
	logic                   rst_r;
	logic                   netb_r;
	logic                   netb_nxt;
	logic                   fetch_r;
	logic                   fetch_nxt;
	logic                   cmpl_r;
	logic                   cmpl_nxt;
	logic                   virq_r;
	logic                   mirq_r;
	logic                   conv_done;
	logic                   conv_bad;

	assign seq_full = {host_s2_r.data, seq_r[55:0]};

	// bring-up sequencer, command byte latch and status byte
	always_comb
	begin
		state_nxt = state_r;
		cfg_nxt = cfg_r;
		seq_nxt = seq_r;
		cnt_nxt = cnt_r;
		err_nxt = err_r;
		cmd_nxt = cmd_r;
		code_nxt = code_r;
		ok_nxt = ok_r;
		pend_nxt = pend_r && !i_cpu_take;
		irq_nxt = 1'b0;
		netb_nxt = 1'b0;
		fetch_nxt = 1'b0;
		cmpl_nxt = 1'b0;
		if (wr_b)
		begin
			cmd_nxt = host_s2_r.data;
			irq_nxt = 1'b1;
			pend_nxt = 1'b1;
		end
		case (state_r)
			vme_port_pkg::st_selftest:
				if (i_selftest_fail)
				begin
					err_nxt = i_fail_code;
					state_nxt = vme_port_pkg::st_failed;
				end
				else if (i_selftest_pass)
				begin
					ok_nxt = 1'b1;
					netb_nxt = strap_r[1];
					state_nxt = strap_r[1] ? vme_port_pkg::st_netboot : vme_port_pkg::st_wait_cfg;
				end
			vme_port_pkg::st_wait_cfg:
				if (wr_b)
				begin
					seq_nxt[{cnt_r, 3'h0} +: 8] = host_s2_r.data;
					cnt_nxt = cnt_r + 3'h1;
					if (cnt_r == `SEQ_CNT_LAST)
					begin
						if (seq_full[15:0] == {`SEQ_PFX_HI, `SEQ_PFX_HI} && seq_full[31:16] == {`SEQ_PFX_LO, `SEQ_PFX_LO}
							&& seq_full[63:62] == 2'b00 && !seq_full[32])
						begin
							cfg_nxt.addr = seq_full[55:32];
							cfg_nxt.am = seq_full[56 +: `AM_BITS];
							fetch_nxt = 1'b1;
							state_nxt = vme_port_pkg::st_fetch;
						end
						else
						begin
							err_nxt = `CODE_BAD_MSG;
							state_nxt = vme_port_pkg::st_failed;
						end
					end
				end
			vme_port_pkg::st_fetch:
				if (i_pat_valid)
					state_nxt = vme_port_pkg::st_check;
			vme_port_pkg::st_check:
				if (conv_done)
				begin
					if (conv_bad)
					begin
						err_nxt = `CODE_BAD_PAT;
						code_nxt = `CODE_BAD_PAT;
						cmpl_nxt = 1'b1;
						state_nxt = vme_port_pkg::st_failed;
					end
					else
						state_nxt = vme_port_pkg::st_config;
				end
			vme_port_pkg::st_config:
				if (i_cfg_result_valid)
				begin
					code_nxt = i_cfg_result_code;
					cmpl_nxt = 1'b1;
					err_nxt = i_cfg_result_code;
					state_nxt = (i_cfg_result_code == `CODE_OK) ? vme_port_pkg::st_ready : vme_port_pkg::st_failed;
				end
			vme_port_pkg::st_netboot,
			vme_port_pkg::st_ready,
			vme_port_pkg::st_failed:
				state_nxt = state_r;
			default:
				state_nxt = vme_port_pkg::st_failed;
		endcase
		if (state_nxt == vme_port_pkg::st_failed)
			ok_nxt = 1'b0;
		if (clear)
		begin
			state_nxt = vme_port_pkg::st_selftest;
			cnt_nxt = '0;
			seq_nxt = '0;
			ok_nxt = 1'b0;
			pend_nxt = 1'b0;
			irq_nxt = 1'b0;
			fetch_nxt = 1'b0;
			cmpl_nxt = 1'b0;
			netb_nxt = 1'b0;
		end
		rdata_nxt = '0;
		rdata_nxt[`ST_OK_BIT] = ok_r;
		rdata_nxt[`ST_PEND_BIT] = pend_r;
	end

	// sequencer registers
	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			state_r <= vme_port_pkg::st_selftest;
			cfg_r <= '0;
			seq_r <= '0;
			cnt_r <= '0;
			err_r <= '0;
			cmd_r <= '0;
			code_r <= '0;
			rdata_r <= '0;
			ok_r <= 1'b0;
			pend_r <= 1'b0;
			irq_r <= 1'b0;
			rst_r <= 1'b0;
			netb_r <= 1'b0;
			fetch_r <= 1'b0;
			cmpl_r <= 1'b0;
			virq_r <= 1'b0;
			mirq_r <= 1'b0;
		end
		else if (i_ce)
		begin
			state_r <= state_nxt;
			cfg_r <= cfg_nxt;
			seq_r <= seq_nxt;
			cnt_r <= cnt_nxt;
			err_r <= err_nxt;
			cmd_r <= cmd_nxt;
			code_r <= code_nxt;
			rdata_r <= rdata_nxt;
			ok_r <= ok_nxt;
			pend_r <= pend_nxt;
			irq_r <= irq_nxt;
			rst_r <= clear;
			netb_r <= netb_nxt;
			fetch_r <= fetch_nxt;
			cmpl_r <= cmpl_nxt;
			virq_r <= i_host_irq_req && !i_irq_by_mem && !clear;
			mirq_r <= i_host_irq_req && i_irq_by_mem && !clear;
		end
	end

	order_conv u_conv
	(
		.i_clock     (i_clock),
		.i_resetn    (i_resetn),
		.i_ce        (i_ce),
		.i_clear     (clear),
		.i_enable    (i_conv_enable),
		.i_analyse   (i_pat_valid && state_r == vme_port_pkg::st_fetch),
		.i_pat_bytes (i_pat_bytes),
		.i_pat_words (i_pat_words),
		.i_pat_long  (i_pat_long),
		.i_data      (i_data),
		.i_dtype     (i_dtype),
		.o_data      (o_data),
		.o_conv      (o_conv),
		.o_done      (conv_done),
		.o_bad       (conv_bad)
	);

	logic [31:0] lcnt_r;
	logic [31:0] lcnt_nxt;
	logic [3:0]  slot_r;
	logic [3:0]  slot_nxt;
	logic        led_r;
	logic        led_nxt;

	// indicator: steady in self-test, blinking when alive, code frames on failure
	always_comb
	begin
		lcnt_nxt = lcnt_r + 32'h1;
		slot_nxt = slot_r;
		led_nxt = led_r;
		if (lcnt_r == 32'(BLINK_CYCLES - 1))
		begin
			lcnt_nxt = '0;
			slot_nxt = (slot_r == `LED_SLOT_LAST) ? 4'h0 : slot_r + 4'h1;
			led_nxt = !led_r;
		end
		if (state_r == vme_port_pkg::st_selftest)
		begin
			lcnt_nxt = '0;
			slot_nxt = '0;
			led_nxt = 1'b1;
		end
		else if (state_r == vme_port_pkg::st_failed)
		begin
			if (slot_r == 4'h0)
				led_nxt = 1'b1;
			else if (slot_r == `LED_SLOT_LAST)
				led_nxt = 1'b0;
			else
				led_nxt = err_r[3'(4'h8 - slot_r)];
		end
	end

	// indicator registers
	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			lcnt_r <= '0;
			slot_r <= '0;
			led_r <= 1'b1;
		end
		else if (i_ce)
		begin
			lcnt_r <= lcnt_nxt;
			slot_r <= slot_nxt;
			led_r <= led_nxt;
		end
	end

	assign o_rdata = rdata_r;
	assign o_board_reset = rst_r;
	assign o_cpu_irq = irq_r;
	assign o_cmd_byte = cmd_r;
	assign o_netboot_req = netb_r;
	assign o_fetch_req = fetch_r;
	assign o_cfg = cfg_r;
	assign o_complete_valid = cmpl_r;
	assign o_complete_code = code_r;
	assign o_vme_irq = virq_r;
	assign o_mem_irq_req = mirq_r;
	assign o_led = led_r;

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_resetn);

	chk_reset_port_write : assert property (
		(i_ce && wr_a) |=> (state_r == vme_port_pkg::st_selftest && !ok_r && o_board_reset))
		else $error("reset port write did not reset the board");
	chk_sysreset_effect : assert property (
		(i_ce && sysr_r[1]) |=> (state_r == vme_port_pkg::st_selftest && !pend_r))
		else $error("system reset did not reset the board");
	chk_status_ok_low : assert property (
		(i_ce && (state_r == vme_port_pkg::st_selftest || state_r == vme_port_pkg::st_failed)) |=> !o_rdata[0])
		else $error("status ok bit set while not passed");
	chk_pend_set : assert property (
		(i_ce && wr_b && !clear) |=> (pend_r ##1 (!i_ce || o_rdata[3])))
		else $error("pending bit not shown after command write");
	chk_cmd_irq : assert property (
		(i_ce && wr_b && !clear) |=> (o_cpu_irq && o_cmd_byte == $past(host_s2_r.data)))
		else $error("command byte not latched with interrupt");
	chk_pend_clear : assert property (
		(i_ce && pend_r && i_cpu_take && !wr_b && !clear) |=> !pend_r)
		else $error("pending bit not cleared by CPU read");
	chk_fetch_start : assert property (
		(i_ce && !clear && state_r == vme_port_pkg::st_wait_cfg && wr_b && cnt_r == 3'h7
			&& host_s2_r.data[7:6] == 2'b00 && seq_r[31:0] == 32'h0000ffff && !seq_r[32])
		|=> (o_fetch_req && o_cfg.addr == $past(seq_r[55:32]) && state_r == vme_port_pkg::st_fetch))
		else $error("valid sequence did not start the fetch");
	chk_fail_sticks : assert property (
		(i_ce && state_r == vme_port_pkg::st_failed && !clear) |=> state_r == vme_port_pkg::st_failed)
		else $error("failed state left without reset");
	chk_led_steady : assert property (
		(i_ce && state_r == vme_port_pkg::st_selftest) [*2] |-> o_led)
		else $error("indicator not steady during self-test");
	chk_bad_pattern : assert property (
		(o_complete_valid && o_complete_code == 8'ha5) |-> state_r == vme_port_pkg::st_failed)
		else $error("bad pattern did not abort bring-up");
	chk_irq_method : assert property (
		(i_ce && i_host_irq_req && !clear) |=> (o_vme_irq != o_mem_irq_req && o_mem_irq_req == $past(i_irq_by_mem)))
		else $error("host interrupt took the wrong path");

endmodule

/* File: logic/vme_port_defs.svh */
// constants for the host port block: status bits, sequence layout, pattern, codes, timing
`ifndef VME_PORT_DEFS_SVH
`define VME_PORT_DEFS_SVH

`define ST_OK_BIT      0
`define ST_PEND_BIT    3
`define SEQ_BYTES      8
`define SEQ_CNT_LAST   3'h7
`define SEQ_PFX_HI     8'hff
`define SEQ_PFX_LO     8'h00
`define AM_BITS        6
`define PAT_BYTES      32'h0f070301
`define PAT_WORD0      16'h0103
`define PAT_LONG       32'h0103070f
`define CODE_OK        8'h00
`define CODE_BAD_PAT   8'ha5
`define CODE_BAD_MSG   8'ha7
`define CLK_HZ         40000000
`define LED_BLINK_MS   250
`define LED_BLINK_CYC  (`LED_BLINK_MS * (`CLK_HZ / 1000))
`define LED_SLOT_LAST  4'h9

`endif

/* File: logic/vme_port_pkg.sv */
// types shared by the host port block and its data order converter
package vme_port_pkg;

	typedef enum logic [2:0] {
		st_selftest,
		st_wait_cfg,
		st_netboot,
		st_fetch,
		st_check,
		st_config,
		st_ready,
		st_failed
	} state_t;

	typedef enum logic [1:0] {
		dt_bytes,
		dt_word,
		dt_long,
		dt_addr
	} dtype_t;

	typedef struct packed {
		logic       sel_b;
		logic       wr;
		logic       rd;
		logic [7:0] data;
	} host_pins_t;

	typedef struct packed {
		logic arr_bswap;
		logic word_bswap;
		logic long_wswap;
		logic long_bswap;
	} conv_t;

	typedef struct packed {
		logic [23:0] addr;
		logic [5:0]  am;
	} cfg_req_t;

endpackage

/* File: logic/order_conv.sv */
// data order analysis of the test pattern and conversion of data read from host memory
`include "vme_port_defs.svh"

module order_conv
(
	input  wire logic                 i_clock,     // 40 MHz clock
	input  wire logic                 i_resetn,    // async reset, active low
	input  wire logic                 i_ce,        // clock enable
	input  wire logic                 i_clear,     // board reset, synchronous
	input  wire logic                 i_enable,    // conversion enabled
	input  wire logic                 i_analyse,   // pattern words are valid
	input  wire logic [31:0]          i_pat_bytes, // pattern offsets 0..3
	input  wire logic [31:0]          i_pat_words, // pattern offsets 4..7
	input  wire logic [31:0]          i_pat_long,  // pattern offsets 8..11
	input  wire logic [31:0]          i_data,      // raw data from host memory
	input  wire vme_port_pkg::dtype_t i_dtype,     // type of i_data
	output logic [31:0]               o_data,      // converted data
	output vme_port_pkg::conv_t       o_conv,      // active conversions
	output logic                      o_done,      // analysis finished, pulse
	output logic                      o_bad        // no consistent conversion
);

	function automatic logic [31:0] swap_b(input logic [31:0] x);
		swap_b = {x[23:16], x[31:24], x[7:0], x[15:8]};
	endfunction

	function automatic logic [31:0] swap_w(input logic [31:0] x);
		swap_w = {x[15:0], x[31:16]};
	endfunction

	function automatic logic [31:0] long_fix(input logic [31:0] x, input logic ws, input logic bs);
		logic [31:0] t;
		t = bs ? swap_b(x) : x;
		long_fix = ws ? swap_w(t) : t;
	endfunction

	vme_port_pkg::conv_t conv_r;
	vme_port_pkg::conv_t conv_nxt;
	logic [31:0]         data_r;
	logic [31:0]         data_nxt;
	logic                done_r;
	logic                done_nxt;
	logic                bad_r;
	logic                bad_nxt;

	// derive each type's conversion from the pattern, then convert by type
	always_comb
	begin
		logic ok_b;
		logic ok_w;
		logic ok_l;
		ok_b = 1'b0;
		ok_w = 1'b0;
		ok_l = 1'b0;
		conv_nxt = conv_r;
		bad_nxt = bad_r;
		done_nxt = 1'b0;
		if (i_clear)
		begin
			conv_nxt = '0;
			bad_nxt = 1'b0;
		end
		else if (i_analyse)
		begin
			done_nxt = 1'b1;
			conv_nxt = '0;
			if (i_enable)
			begin
				ok_b = (i_pat_bytes == `PAT_BYTES) || (swap_b(i_pat_bytes) == `PAT_BYTES);
				conv_nxt.arr_bswap = (i_pat_bytes != `PAT_BYTES);
				ok_w = (i_pat_words[15:0] == `PAT_WORD0)
					|| ({i_pat_words[7:0], i_pat_words[15:8]} == `PAT_WORD0);
				conv_nxt.word_bswap = (i_pat_words[15:0] != `PAT_WORD0);
				for (int k = 0; k < 4; k++)
				begin
					if (!ok_l && long_fix(i_pat_long, k[1], k[0]) == `PAT_LONG)
					begin
						ok_l = 1'b1;
						conv_nxt.long_wswap = k[1];
						conv_nxt.long_bswap = k[0];
					end
				end
				bad_nxt = !(ok_b && ok_w && ok_l);
			end
			else
				bad_nxt = 1'b0;
		end
		case (i_dtype)
			vme_port_pkg::dt_bytes: data_nxt = conv_r.arr_bswap ? swap_b(i_data) : i_data;
			vme_port_pkg::dt_word:  data_nxt = conv_r.word_bswap ? swap_b(i_data) : i_data;
			vme_port_pkg::dt_long,
			vme_port_pkg::dt_addr:  data_nxt = long_fix(i_data, conv_r.long_wswap, conv_r.long_bswap);
			default:                data_nxt = i_data;
		endcase
	end

	// register analysis result and converted data
	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			conv_r <= '0;
			data_r <= '0;
			done_r <= 1'b0;
			bad_r <= 1'b0;
		end
		else if (i_ce)
		begin
			conv_r <= conv_nxt;
			data_r <= data_nxt;
			done_r <= done_nxt;
			bad_r <= bad_nxt;
		end
	end

	assign o_conv = conv_r;
	assign o_data = data_r;
	assign o_done = done_r;
	assign o_bad = bad_r;

endmodule

/* File: test/host_model.sv */
// host driver model: writes and reads the two byte ports
module host_model
(
	input  wire logic                i_clock,  // bench clock
	input  wire logic [7:0]          i_status, // status byte seen by the host
	output vme_port_pkg::host_pins_t o_host    // port strobes and data
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned to_cnt = 0; // polls that ran out
	initial o_host = '0;
	// one byte write after polling the pending flag clear
	task automatic put(input logic sel, input logic [7:0] val);
		int i;
		for (i = 0; i < 64 && i_status[3] !== 1'b0; i++)
			@(posedge i_clock);
		to_cnt += (i == 64);
		@(posedge i_clock);
		o_host <= '{sel_b: sel, wr: 1'b1, rd: 1'b0, data: val};
		repeat (4) @(posedge i_clock);
		o_host <= '{sel_b: sel, wr: 1'b0, rd: 1'b0, data: ~val};
		repeat (4) @(posedge i_clock);
	endtask
	// read strobe on a port
	task automatic peek(input logic sel);
		@(posedge i_clock);
		o_host <= '{sel_b: sel, wr: 1'b0, rd: 1'b1, data: 8'h5a};
		repeat (4) @(posedge i_clock);
		o_host <= '{sel_b: sel, wr: 1'b0, rd: 1'b0, data: 8'ha5};
		repeat (4) @(posedge i_clock);
	endtask
	// wait for self-test ok, giving up after 200 clocks
	task automatic wait_ok(output logic ok);
		int i;
		for (i = 0; i < 200 && i_status[0] !== 1'b1; i++)
			@(posedge i_clock);
		ok = (i < 200);
	endtask
	// the eight byte address sequence
	task automatic send_addr(input logic [23:0] a, input logic [5:0] am);
		put(1'b1, 8'hff);
		put(1'b1, 8'hff);
		put(1'b1, 8'h00);
		put(1'b1, 8'h00);
		put(1'b1, a[7:0]);
		put(1'b1, a[15:8]);
		put(1'b1, a[23:16]);
		put(1'b1, {2'h0, am});
	endtask
endmodule

/* File: test/tb.sv */
// self-checking bench of the host port block
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clock = 0, i_resetn = 0, sysrst = 0, strap = 0, pass = 0, fail = 0, take = 0, man = 0;
	logic conv_en = 0, pvalid = 0, rvalid = 0, irq_req = 0, by_mem = 0, auto_take = 1, ok, l0;
	logic [7:0] fcode = 8'h00, rcode = 8'h00, cmd, cplt, rdata;
	logic [31:0] pw = 32'h0, pl = 32'h0, data = 32'h0, v, dout;
	logic [31:0] pb = 32'h0f070301;
	logic brst, irq, nreq, freq, cvalid, vme_irq, mem_irq, led;
	vme_port_pkg::dtype_t dtype = vme_port_pkg::dt_bytes;
	vme_port_pkg::host_pins_t host;
	vme_port_pkg::cfg_req_t cfg;
	vme_port_pkg::conv_t conv;
	int n_fail = 0, n_tests = 0, n_brst = 0, n_irq = 0, n_fetch = 0, n_net = 0, n_cmpl = 0, seed = 22, k;
	logic [7:0] last_cmd;
	vme_port_pkg::cfg_req_t cfg_seen;

	host_model host_u (.i_clock(i_clock), .i_status(rdata), .o_host(host));
	vme_host_port #(.BLINK_CYCLES(4)) dut_u (.i_clock(i_clock), .i_resetn(i_resetn), .i_ce(1'b1),
		.i_sysreset(sysrst), .i_host(host), .i_netboot_strap(strap), .i_selftest_pass(pass),
		.i_selftest_fail(fail), .i_fail_code(fcode), .i_cpu_take(take), .i_conv_enable(conv_en),
		.i_pat_valid(pvalid), .i_pat_bytes(pb), .i_pat_words(pw), .i_pat_long(pl),
		.i_data(data), .i_dtype(dtype), .i_cfg_result_valid(rvalid), .i_cfg_result_code(rcode),
		.i_host_irq_req(irq_req), .i_irq_by_mem(by_mem), .o_rdata(rdata), .o_board_reset(brst),
		.o_cpu_irq(irq), .o_cmd_byte(cmd), .o_netboot_req(nreq), .o_fetch_req(freq), .o_cfg(cfg),
		.o_data(dout), .o_conv(conv), .o_complete_valid(cvalid), .o_complete_code(cplt),
		.o_vme_irq(vme_irq), .o_mem_irq_req(mem_irq), .o_led(led));

	// clock of 25 ns
	initial forever #12.5 i_clock = ~i_clock;

	// local cpu takes each byte, and tallies of the pulses
	always @(posedge i_clock)
	begin
		take <= (auto_take & irq) | man;
		n_brst += (brst === 1'b1);
		n_irq += (irq === 1'b1);
		n_net += (nreq === 1'b1);
		n_fetch += (freq === 1'b1);
		n_cmpl += (cvalid === 1'b1);
		last_cmd <= (irq === 1'b1) ? cmd : last_cmd;
		cfg_seen <= (freq === 1'b1) ? cfg : cfg_seen;
	end

	function automatic logic [31:0] rev(input logic [31:0] x);
		return {x[7:0], x[15:8], x[23:16], x[31:24]};
	endfunction
	function automatic logic [31:0] swb(input logic [31:0] x);
		return {x[23:16], x[31:24], x[7:0], x[15:8]};
	endfunction
	task automatic tick(input int n);
		repeat (n) @(posedge i_clock);
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// self-test pass, address sequence, then the pattern words
	task automatic bring(input logic [31:0] w, input logic [31:0] l);
		logic [23:0] a;
		k = n_fetch;
		pass <= 1'b1;
		tick(1);
		pass <= 1'b0;
		host_u.wait_ok(ok);
		check("self-test ok", ok, 1);
		v = $random(seed);
		a = {v[23:1], 1'b0};
		host_u.send_addr(a, v[29:24]);
		check("fetch", n_fetch - k, 1);
		check("address", cfg_seen, {a, v[29:24]});
		pw <= w;
		pl <= l;
		pvalid <= 1'b1;
		tick(1);
		pvalid <= 1'b0;
		tick(3);
	endtask
	// soft reset through the reset port
	task automatic port_reset;
		k = n_brst;
		host_u.put(1'b0, 8'h3c);
		check("reset write", n_brst - k, 1);
		check("ok after reset", rdata[0], 0);
	endtask

	// watchdog
	initial
	begin
		tick(20000);
		n_fail++;
		end_of_test;
	end

	// main sequence
	initial
	begin
		tick(10);
		check("led in reset", led, 1);
		check("status in reset", rdata, 0);
		i_resetn <= 1'b1;
		tick(12);
		check("led steady", led, 1);
		check("ok clear", rdata[0], 0);
		conv_en <= 1'b1;
		bring(32'h070f0103, 32'h0103070f);
		check("conv little", conv, 4'h0);
		v = $random(seed);
		data <= v;
		dtype <= vme_port_pkg::dt_addr;
		tick(2);
		check("addr data", dout, v);
		k = n_cmpl;
		rvalid <= 1'b1;
		tick(1);
		rvalid <= 1'b0;
		tick(3);
		check("complete", cplt, 8'h00);
		check("complete strobe", n_cmpl - k, 1);
		k = 0;
		repeat (10)
		begin
			l0 = led;
			tick(1);
			k += (led !== l0);
		end
		check("blink", k >= 2, 1);
		k = n_brst;
		sysrst <= 1'b1;
		tick(6);
		check("sysreset", n_brst != k, 1);
		check("ok after sysreset", rdata[0], 0);
		sysrst <= 1'b0;
		pb <= 32'h070f0103;
		tick(4);
		bring(32'h0f070301, 32'h0f070301);
		check("conv big", conv, 4'hf);
		data <= v;
		dtype <= vme_port_pkg::dt_long;
		tick(2);
		check("long data", dout, rev(v));
		dtype <= vme_port_pkg::dt_word;
		tick(2);
		check("word data", dout, swb(v));
		dtype <= vme_port_pkg::dt_bytes;
		tick(2);
		check("array data", dout, swb(v));
		port_reset;
		bring(32'h0, 32'h0);
		check("bad pattern", cplt, 8'ha5);
		port_reset;
		k = n_brst;
		host_u.peek(1'b0);
		check("reset read", n_brst - k, 0);
		auto_take <= 1'b0;
		v = $random(seed);
		k = n_irq;
		host_u.put(1'b1, v[7:0]);
		check("cpu irq", n_irq - k, 1);
		check("cmd byte", last_cmd, v[7:0]);
		check("pending", rdata[3], 1);
		man <= 1'b1;
		tick(1);
		man <= 1'b0;
		tick(4);
		check("pending clear", rdata[3], 0);
		auto_take <= 1'b1;
		fcode <= v[15:8];
		fail <= 1'b1;
		tick(1);
		fail <= 1'b0;
		tick(20);
		check("failed ok", rdata[0], 0);
		port_reset;
		conv_en <= 1'b0;
		bring(32'h070f0103, 32'h0f070301);
		check("conv off", conv, 4'h0);
		port_reset;
		pass <= 1'b1;
		tick(1);
		pass <= 1'b0;
		host_u.wait_ok(ok);
		k = n_fetch;
		host_u.send_addr(24'h000001, 6'h3d);
		check("odd address", n_fetch - k, 0);
		check("ok on error", rdata[0], 0);
		port_reset;
		strap <= 1'b1;
		k = n_net;
		tick(4);
		pass <= 1'b1;
		tick(1);
		pass <= 1'b0;
		tick(6);
		check("netboot", n_net - k, 1);
		for (int m = 0; m < 2; m++)
		begin
			irq_req <= 1'b1;
			by_mem <= m[0];
			tick(3);
			check("host irq", {vme_irq, mem_irq}, m ? 2'h1 : 2'h2);
		end
		check("host polls", host_u.to_cnt, 0);
		end_of_test;
	end
endmodule
